// File: adc_cal_cfg.svh
// Offsets, field positions, reset values, per-rate constants and timing counts
`ifndef ADC_CAL_CFG_SVH
`define ADC_CAL_CFG_SVH

// Master clock rate
`define CLK_MHZ 50

// Register indices on the documented register port
`define REG_IDX_CONTROL 2'h0
`define REG_IDX_OFFSET 2'h1
`define REG_IDX_FULLSCALE 2'h2

// Clock-out rate select field inside the converter control register
`define CLKOUT_SEL_HI_BIT 6
`define CLKOUT_SEL_LO_BIT 5
`define CLKOUT_OFF 2'h0
`define CLKOUT_DIV1 2'h1
`define CLKOUT_DIV2 2'h2
`define CLKOUT_DIV4 2'h3
`define CLKOUT_SEL_RST 2'h1

// Coefficient reset values, overwritten by the automatic calibration
`define OFC_RST 24'h00_0000
`define FSC_RST 24'h44_AC08
`define FSC_MAX 24'hFF_FFFF

// Alpha per rate group
`define ALPHA_FAST 24'h40_0000
`define ALPHA_MID 24'h3C_0000
`define ALPHA_SLOW50 24'h4B_0000
`define ALPHA_SLOW60 24'h3E_8000
`define ALPHA_SLOWEST 24'h5D_C000

// 2^39 / alpha, used instead of a divider in the conversion path
`define RECIP_FAST 18'h2_0000
`define RECIP_MID 18'h2_2222
`define RECIP_SLOW50 18'h1_B4E8
`define RECIP_SLOW60 18'h2_0C4A
`define RECIP_SLOWEST 18'h1_5D86

// Beta per rate group, unsigned with 14 fraction bits
`define BETA_FAST 16'h774A
`define BETA_MID 16'h6FD5
`define BETA_SLOW50 16'h8BCC
`define BETA_SLOW60 16'h747E
`define BETA_SLOWEST 16'hAEBF

// Fixed-point shifts of the correction equation
`define OFS_SHIFT 16
`define ALPHA_SHIFT 23
`define BETA_SHIFT 14
`define OUT_SHIFT 37
`define DIV_TOP_BIT 6'd46

// Input settling time before a calibration sample is taken
`define CAL_SETTLE_US 20
`define CAL_SETTLE_CYC (`CAL_SETTLE_US * `CLK_MHZ)

`endif

// File: adc_cal_pkg.sv
// Types shared by the calibration and clock-output logic
package adc_cal_pkg;

  typedef enum logic [1:0] {
    SEL_CONTROL,
    SEL_OFFSET,
    SEL_FULLSCALE
  } reg_sel_t;

  typedef enum logic [2:0] {
    CMD_SELF_OFS,
    CMD_SELF_GAIN,
    CMD_SELF_FULL,
    CMD_SYS_OFS,
    CMD_SYS_GAIN
  } cal_cmd_t;

  typedef enum logic [2:0] {
    RATE_FAST,
    RATE_MID,
    RATE_SLOW50,
    RATE_SLOW60,
    RATE_SLOWEST
  } rate_group_t;

  typedef enum logic [1:0] {
    PH_SELF_OFS,
    PH_SELF_GAIN,
    PH_SYS_OFS,
    PH_SYS_GAIN
  } cal_phase_t;

  typedef enum logic [1:0] {
    CAL_IDLE,
    CAL_SETTLE,
    CAL_MEASURE,
    CAL_DIVIDE
  } cal_state_t;

  typedef struct packed {
    logic [23:0] offset_correction_coef;
    logic [23:0] fullscale_correction_coef;
  } coef_t;

  typedef struct packed {
    logic [23:0] alpha;
    logic [17:0] recip;
    logic [15:0] beta;
  } rate_const_t;

endpackage : adc_cal_pkg

// File: clkout_gen.sv
// Glitch-free divided clock output for the shared general-purpose pin
`timescale 1ns/100ps
`default_nettype none
`include "adc_cal_cfg.svh"

module clkout_gen (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] sel,
  output logic pin_o,
  output logic pin_oe_n
);
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic [1:0] act_q;
  logic [1:0] act_d;
  logic en1_q;
  logic en1_d;

  ////////////////////////////////////////////////////////////////////////////
  // New settings are taken only when the divider wraps, so every divided
  // output finishes its current period before the switch
  always_comb
  begin
    cnt_d = cnt_q + 2'h1;
    act_d = act_q;
    if (cnt_q == 2'h3)
    begin
      act_d = sel; // R1 R22
    end
    en1_d = (act_d == `CLKOUT_DIV1);
  end

  // Falling-edge flops: the enable for the undivided clock only moves
  // while the clock is low, so no runt pulse reaches the pin
  always_ff @(negedge clk)
  begin
    if (rst)
    begin
      cnt_q <= 2'h0;
      act_q <= `CLKOUT_SEL_RST;
      en1_q <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_d;
      act_q <= act_d;
      en1_q <= en1_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    case (act_q)
      `CLKOUT_DIV1: pin_o = clk & en1_q; // R1
      `CLKOUT_DIV2: pin_o = cnt_q[0]; // R1
      `CLKOUT_DIV4: pin_o = cnt_q[1]; // R1
      default: pin_o = 1'b0;
    endcase
    pin_oe_n = (act_q == `CLKOUT_OFF);
  end

endmodule : clkout_gen
`default_nettype wire

// File: adc_cal_ctrl.sv
// Offset/full-scale correction, calibration sequencer and clock-output control
`timescale 1ns/100ps
`default_nettype none
`include "adc_cal_cfg.svh"
// Overview of operation
// [R1] Clock out at full, half or quarter rate
// [R2] Standby leaves the clock output running
// [R3] Host disables unused clock output after reset
// [R4] Two 24-bit readable, writable coefficient registers
// [R5] Output equals corrected input scaled by coefficients
// [R6] Offset coefficient is signed 24-bit
// [R7] Full-scale coefficient is unsigned 24-bit
// [R8] Alpha and beta chosen per data rate
// [R9] Five calibration commands, accepted any time
// [R10] Ready line high throughout calibration
// [R11] First result after calibration is settled
// [R12] Reset starts an automatic self calibration
// [R13] Host recalibrates after rate changes
// [R14] Host self-calibrates once reference settles
// [R15] Self offset ties inputs to mid-supply
// [R16] Calibration time counted in master clocks
// [R17] Falling ready edge marks new result
// [R18] Full self calibration: offset, then gain
// [R19] Self gain result goes to full-scale
// [R20] System offset result goes to offset
// [R21] Host coefficient writes apply from next result
// [R22] Clock-out select changes without runt pulses

module adc_cal_ctrl (
  input wire logic clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire adc_cal_pkg::reg_sel_t reg_sel,
  input wire logic [23:0] reg_wdata,
  output logic [23:0] reg_rdata,
  input wire logic cmd_valid,
  input wire adc_cal_pkg::cal_cmd_t cmd,
  input wire adc_cal_pkg::rate_group_t rate_grp,
  input wire logic standby,
  input wire logic raw_valid,
  input wire logic [23:0] raw_data,
  output logic [23:0] result_data,
  output logic result_ready_n,
  output logic cal_busy,
  output logic cal_inputs_mid,
  output logic cal_inputs_ref,
  output logic gpio0_clock_output_pin,
  output logic gpio0_oe_n
);
  import adc_cal_pkg::*;

  function automatic rate_const_t rate_lookup(input rate_group_t g);
    rate_const_t r;
    case (g)
      RATE_MID: r = '{alpha: `ALPHA_MID, recip: `RECIP_MID, beta: `BETA_MID};
      RATE_SLOW50: r = '{alpha: `ALPHA_SLOW50, recip: `RECIP_SLOW50, beta: `BETA_SLOW50};
      RATE_SLOW60: r = '{alpha: `ALPHA_SLOW60, recip: `RECIP_SLOW60, beta: `BETA_SLOW60};
      RATE_SLOWEST: r = '{alpha: `ALPHA_SLOWEST, recip: `RECIP_SLOWEST, beta: `BETA_SLOWEST};
      default: r = '{alpha: `ALPHA_FAST, recip: `RECIP_FAST, beta: `BETA_FAST};
    endcase
    return r;
  endfunction : rate_lookup

  // Offset term ofc/alpha in input codes, via the stored reciprocal
  function automatic logic signed [26:0] ofs_term(input logic [23:0] offset_correction_coef,
                                                  input logic [17:0] recip);
    logic signed [42:0] p;
    p = $signed(offset_correction_coef) * $signed({1'b0, recip}); // R6
    return 27'(p >>> `OFS_SHIFT);
  endfunction : ofs_term

  rate_const_t rc;
  coef_t coef_q;
  coef_t coef_d;
  logic [1:0] clk_sel_q;
  logic [1:0] clk_sel_d;
  logic [23:0] rdata_q;
  logic [23:0] rdata_d;
  cal_state_t state_q;
  cal_state_t state_d;
  cal_phase_t phase_q;
  cal_phase_t phase_d;
  logic chain_q;
  logic chain_d;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic [47:0] rem_q;
  logic [47:0] rem_d;
  logic [46:0] quo_q;
  logic [46:0] quo_d;
  logic [47:0] den_q;
  logic [47:0] den_d;
  logic [5:0] bit_q;
  logic [5:0] bit_d;
  logic cal_wr_ofc;
  logic cal_wr_fsc;
  logic [23:0] cal_ofc;
  logic [23:0] cal_fsc;
  logic [47:0] div_r;
  logic signed [48:0] ofs_prod;
  logic signed [26:0] gain_d;
  logic signed [43:0] gain_prod;

  assign rc = rate_lookup(rate_grp); // R8

  ////////////////////////////////////////////////////////////////////////////
  // Register port; a calibration result wins over a host write in the same cycle
  always_comb
  begin
    coef_d = coef_q;
    clk_sel_d = clk_sel_q;
    if (reg_wr)
    begin
      case (reg_sel)
        SEL_CONTROL: clk_sel_d = {reg_wdata[`CLKOUT_SEL_HI_BIT], reg_wdata[`CLKOUT_SEL_LO_BIT]};
        SEL_OFFSET: coef_d.offset_correction_coef = reg_wdata; // R4
        SEL_FULLSCALE: coef_d.fullscale_correction_coef = reg_wdata; // R4
        default: coef_d = coef_q;
      endcase
    end
    if (cal_wr_ofc)
    begin
      coef_d.offset_correction_coef = cal_ofc;
    end
    if (cal_wr_fsc)
    begin
      coef_d.fullscale_correction_coef = cal_fsc;
    end
    rdata_d = 24'h00_0000;
    case (reg_sel)
      SEL_CONTROL:
      begin
        rdata_d[`CLKOUT_SEL_HI_BIT] = clk_sel_q[1];
        rdata_d[`CLKOUT_SEL_LO_BIT] = clk_sel_q[0];
      end
      SEL_OFFSET: rdata_d = coef_q.offset_correction_coef; // R4
      SEL_FULLSCALE: rdata_d = coef_q.fullscale_correction_coef; // R4
      default: rdata_d = 24'h00_0000;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      coef_q <= '{offset_correction_coef: `OFC_RST, fullscale_correction_coef: `FSC_RST};
      clk_sel_q <= `CLKOUT_SEL_RST;
      rdata_q <= 24'h00_0000;
    end
    else
    begin
      coef_q <= coef_d;
      clk_sel_q <= clk_sel_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Calibration sequencer: settle, take one sample, compute, store
  always_comb
  begin
    ofs_prod = $signed(raw_data) * $signed({1'b0, rc.alpha});
    gain_d = 27'($signed(raw_data)) - ofs_term(coef_q.offset_correction_coef, rc.recip);
    gain_prod = gain_d * $signed({1'b0, rc.beta});
    div_r = {rem_q[46:0], (bit_q == `DIV_TOP_BIT)};
    state_d = state_q;
    phase_d = phase_q;
    chain_d = chain_q;
    cnt_d = cnt_q;
    rem_d = rem_q;
    quo_d = quo_q;
    den_d = den_q;
    bit_d = bit_q;
    cal_wr_ofc = 1'b0;
    cal_wr_fsc = 1'b0;
    cal_ofc = 24'(ofs_prod >>> `ALPHA_SHIFT);
    cal_fsc = (|quo_q[46:24]) ? `FSC_MAX : quo_q[23:0]; // R7
    case (state_q)
      CAL_SETTLE:
      begin
        cnt_d = cnt_q + 16'h0001; // R16
        if (cnt_q == 16'(`CAL_SETTLE_CYC - 1))
        begin
          state_d = CAL_MEASURE;
        end
      end
      CAL_MEASURE:
      begin
        if (raw_valid)
        begin
          if (phase_q == PH_SELF_OFS || phase_q == PH_SYS_OFS)
          begin
            cal_wr_ofc = 1'b1; // R20
            if (chain_q)
            begin
              state_d = CAL_SETTLE; // R18
              phase_d = PH_SELF_GAIN;
              chain_d = 1'b0;
              cnt_d = 16'h0000;
            end
            else
            begin
              state_d = CAL_IDLE;
            end
          end
          else
          begin
            // Non-positive readings cannot give a gain; divide by one instead
            den_d = (gain_prod > 44'sd0) ? 48'(gain_prod >>> `BETA_SHIFT) : 48'h0000_0000_0001;
            if (den_d == 48'h0000_0000_0000)
            begin
              den_d = 48'h0000_0000_0001;
            end
            rem_d = 48'h0000_0000_0000;
            quo_d = 47'h0000_0000_0000;
            bit_d = `DIV_TOP_BIT;
            state_d = CAL_DIVIDE;
          end
        end
      end
      CAL_DIVIDE:
      begin
        if (div_r >= den_q)
        begin
          rem_d = div_r - den_q;
          quo_d = {quo_q[45:0], 1'b1};
        end
        else
        begin
          rem_d = div_r;
          quo_d = {quo_q[45:0], 1'b0};
        end
        bit_d = bit_q - 6'h01;
        if (bit_q == 6'h00)
        begin
          state_d = CAL_IDLE;
        end
      end
      default:
      begin
        state_d = CAL_IDLE;
      end
    endcase
    // Divider finished last cycle: store the full-scale result
    if (state_q == CAL_IDLE && bit_q == 6'h3F)
    begin
      cal_wr_fsc = 1'b1; // R19
      bit_d = 6'h00;
    end
    if (state_q == CAL_DIVIDE && bit_q == 6'h00)
    begin
      bit_d = 6'h3F;
    end
    // A new command restarts calibration from any state
    if (cmd_valid)
    begin
      state_d = CAL_SETTLE; // R9
      cnt_d = 16'h0000;
      chain_d = (cmd == CMD_SELF_FULL); // R18
      case (cmd)
        CMD_SELF_GAIN: phase_d = PH_SELF_GAIN;
        CMD_SYS_OFS: phase_d = PH_SYS_OFS;
        CMD_SYS_GAIN: phase_d = PH_SYS_GAIN;
        default: phase_d = PH_SELF_OFS;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q <= CAL_SETTLE; // R12
      phase_q <= PH_SELF_OFS;
      chain_q <= 1'b1;
      cnt_q <= 16'h0000;
      rem_q <= 48'h0000_0000_0000;
      quo_q <= 47'h0000_0000_0000;
      den_q <= 48'h0000_0000_0001;
      bit_q <= 6'h00;
    end
    else
    begin
      state_q <= state_d;
      phase_q <= phase_d;
      chain_q <= chain_d;
      cnt_q <= cnt_d;
      rem_q <= rem_d;
      quo_q <= quo_d;
      den_q <= den_d;
      bit_q <= bit_d;
    end
  end

  assign cal_busy = (state_q != CAL_IDLE) || (bit_q == 6'h3F);
  assign cal_inputs_mid = (state_q != CAL_IDLE) && (phase_q == PH_SELF_OFS); // R15
  assign cal_inputs_ref = (state_q != CAL_IDLE) && (phase_q == PH_SELF_GAIN);

  ////////////////////////////////////////////////////////////////////////////
  // Conversion path: coefficients are snapshotted with each sample
  logic signed [23:0] x_q;
  logic signed [23:0] x_d;
  coef_t snap_q;
  coef_t snap_d;
  rate_const_t rsnap_q;
  rate_const_t rsnap_d;
  logic v1_q;
  logic v1_d;
  logic [23:0] res_q;
  logic [23:0] res_d;
  logic rdy_n_q;
  logic rdy_n_d;
  logic signed [26:0] corr;
  logic signed [68:0] prod;
  logic signed [31:0] scaled;

  always_comb
  begin
    corr = 27'(x_q) - ofs_term(snap_q.offset_correction_coef, rsnap_q.recip); // R5
    prod = corr * $signed({1'b0, snap_q.fullscale_correction_coef}) * $signed({1'b0, rsnap_q.beta}); // R5 R7
    scaled = 32'(prod >>> `OUT_SHIFT);
    x_d = x_q;
    snap_d = snap_q;
    rsnap_d = rsnap_q;
    v1_d = 1'b0;
    res_d = res_q;
    rdy_n_d = rdy_n_q;
    if (raw_valid && !cal_busy)
    begin
      x_d = $signed(raw_data);
      snap_d = coef_q; // R21
      rsnap_d = rc;
      v1_d = 1'b1;
      rdy_n_d = 1'b1;
    end
    if (v1_q)
    begin
      if (scaled > 32'sh007F_FFFF)
      begin
        res_d = 24'h7F_FFFF;
      end
      else if (scaled < -32'sh0080_0000)
      begin
        res_d = 24'h80_0000;
      end
      else
      begin
        res_d = scaled[23:0];
      end
      rdy_n_d = 1'b0; // R17 R11
    end
    // Ready rises on the edge that takes a command, not one cycle later
    if (cal_busy || cmd_valid)
    begin
      v1_d = 1'b0;
      rdy_n_d = 1'b1; // R10
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      x_q <= 24'sh00_0000;
      snap_q <= '{offset_correction_coef: `OFC_RST, fullscale_correction_coef: `FSC_RST};
      rsnap_q <= '{alpha: `ALPHA_FAST, recip: `RECIP_FAST, beta: `BETA_FAST};
      v1_q <= 1'b0;
      res_q <= 24'h00_0000;
      rdy_n_q <= 1'b1;
    end
    else
    begin
      x_q <= x_d;
      snap_q <= snap_d;
      rsnap_q <= rsnap_d;
      v1_q <= v1_d;
      res_q <= res_d;
      rdy_n_q <= rdy_n_d;
    end
  end

  assign result_data = res_q;
  assign result_ready_n = rdy_n_q;

  ////////////////////////////////////////////////////////////////////////////
  // Standby is deliberately not wired in: the clock output keeps running
  logic standby_unused;
  assign standby_unused = standby; // R2

  clkout_gen u_clkout (
    .clk(clk),
    .rst(rst),
    .sel(clk_sel_q), // R1
    .pin_o(gpio0_clock_output_pin),
    .pin_oe_n(gpio0_oe_n)
  );

endmodule : adc_cal_ctrl
`default_nettype wire

// File: adc_cal_ctrl_monitor.sv
// Concurrent checks on the calibration and clock-output controller ports
`timescale 1ns/100ps
`default_nettype none
module adc_cal_ctrl_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire adc_cal_pkg::reg_sel_t reg_sel,
  input wire logic [23:0] reg_wdata,
  input wire logic [23:0] reg_rdata,
  input wire logic cmd_valid,
  input wire adc_cal_pkg::cal_cmd_t cmd,
  input wire adc_cal_pkg::rate_group_t rate_grp,
  input wire logic standby,
  input wire logic raw_valid,
  input wire logic [23:0] raw_data,
  input wire logic [23:0] result_data,
  input wire logic result_ready_n,
  input wire logic cal_busy,
  input wire logic cal_inputs_mid,
  input wire logic cal_inputs_ref,
  input wire logic gpio0_clock_output_pin,
  input wire logic gpio0_oe_n
);
  import adc_cal_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  // Busy length since the last command, saturating so it never wraps
  logic [10:0] busy_cnt_q;
  logic [10:0] busy_cnt_d;
  always_comb
  begin
    busy_cnt_d = busy_cnt_q;
    if (cmd_valid)
      busy_cnt_d = 11'h000;
    else if (cal_busy && busy_cnt_q != 11'h7ff)
      busy_cnt_d = busy_cnt_q + 11'h001;
  end
  always_ff @(posedge clk)
  begin
    busy_cnt_q <= rst ? 11'h000 : busy_cnt_d;
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence s_cmd(cal_cmd_t c);
    cmd_valid && cmd == c;
  endsequence
  sequence s_accept;
    raw_valid && !cal_busy && !cmd_valid;
  endsequence
  sequence s_result;
    result_ready_n ##1 !result_ready_n;
  endsequence
  sequence s_ofs_wr;
    reg_wr && reg_sel == SEL_OFFSET && !cal_busy && !cmd_valid ##1 reg_sel == SEL_OFFSET;
  endsequence
  a_sample_result: assert property (s_accept ##1 !cmd_valid |-> s_result)
    else $error("accepted sample gave no result");
  a_fall_cause: assert property ($fell(result_ready_n) |-> $past(raw_valid, 2) && !$past(cal_busy, 2))
    else $error("ready fell without an accepted sample");
  a_busy_ready_high: assert property (cal_busy |-> result_ready_n)
    else $error("ready low during calibration");
  a_cmd_starts_cal: assert property (cmd_valid |=> cal_busy && result_ready_n)
    else $error("command did not start calibration");
  a_self_ofs_mid: assert property (s_cmd(CMD_SELF_OFS) or s_cmd(CMD_SELF_FULL) |=> cal_inputs_mid && !cal_inputs_ref)
    else $error("self offset inputs not at mid-supply");
  a_self_gain_ref: assert property (s_cmd(CMD_SELF_GAIN) |=> cal_inputs_ref && !cal_inputs_mid)
    else $error("self gain phase without reference inputs");
  a_full_order: assert property ($fell(cal_inputs_mid) && cal_busy && !$past(cmd_valid) |-> cal_inputs_ref)
    else $error("gain phase did not follow offset");
  a_settle_len: assert property ($fell(cal_busy) |-> busy_cnt_q >= 11'h3e8)
    else $error("calibration too short");
  a_ofs_readback: assert property (s_ofs_wr |=> reg_rdata == $past(reg_wdata, 2))
    else $error("offset write not read back");
  a_ctrl_spare_zero: assert property (reg_sel == SEL_CONTROL ##1 reg_sel == SEL_CONTROL |-> reg_rdata[23:7] == 17'h0_0000 && reg_rdata[4:0] == 5'h00)
    else $error("control register spare bits not zero");
  a_clkout_off: assert property (reg_wr && reg_sel == SEL_CONTROL && reg_wdata[6:5] == 2'h0 ##1 !(reg_wr && reg_sel == SEL_CONTROL) [*6] |=> gpio0_oe_n)
    else $error("clock output still driven after disable");
endmodule : adc_cal_ctrl_monitor
bind adc_cal_ctrl adc_cal_ctrl_monitor u_mon (.clk, .rst, .reg_wr, .reg_sel, .reg_wdata,
  .reg_rdata, .cmd_valid, .cmd, .rate_grp, .standby, .raw_valid, .raw_data, .result_data,
  .result_ready_n, .cal_busy, .cal_inputs_mid, .cal_inputs_ref, .gpio0_clock_output_pin,
  .gpio0_oe_n);
`default_nettype wire

// File: sample_source.sv
// Filter-side model: one raw sample every 64 cycles while enabled
`timescale 1ns/100ps
`default_nettype none
module sample_source (
  input wire logic clk,
  input wire logic rst,
  input wire logic en,
  input wire logic [23:0] value,
  output logic raw_valid,
  output logic [23:0] raw_data
);
  logic [5:0] cnt;
  // Long spacing keeps a pulse from landing on the edge a calibration ends
  always @(posedge clk)
  begin
    cnt <= (rst || !en) ? 6'h00 : cnt + 6'h01;
    raw_valid <= !rst && en && cnt == 6'h3f;
    // Data is not held outside the pulse
    raw_data <= rst ? 24'h00_0000 : (en && cnt == 6'h3f) ? value : ~raw_data;
  end
endmodule : sample_source
`default_nettype wire

// File: adc_calibration_and_clock_out_test.sv
// Self-checking bench for the calibration and clock-output controller
`timescale 1ns/100ps
`default_nettype none
`include "adc_cal_cfg.svh"
module adc_calibration_and_clock_out_test;
  import adc_cal_pkg::*;
  logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, cmd_valid = 1'b0, standby = 1'b0, en = 1'b0;
  reg_sel_t reg_sel = SEL_CONTROL;
  cal_cmd_t cmd = CMD_SELF_OFS;
  rate_group_t rate_grp = RATE_FAST;
  logic [23:0] reg_wdata = 24'h00_0000, src_val = 24'h00_0100, m_ofc, m_fsc, raw;
  wire logic [23:0] reg_rdata, raw_data, result_data;
  wire logic raw_valid, result_ready_n, cal_busy, cal_inputs_mid, cal_inputs_ref;
  wire logic gpio0_clock_output_pin, gpio0_oe_n;
  int num_errors = 0, tests_run = 0, edges = 0;
  integer seed = 32'h5415_d9ab;
  logic rdy_q = 1'b1;
  logic [23:0] exp_q[$];
  logic [23:0] al [5] = '{`ALPHA_FAST, `ALPHA_MID, `ALPHA_SLOW50, `ALPHA_SLOW60, `ALPHA_SLOWEST};
  logic [17:0] rc [5] = '{`RECIP_FAST, `RECIP_MID, `RECIP_SLOW50, `RECIP_SLOW60, `RECIP_SLOWEST};
  logic [15:0] bt [5] = '{`BETA_FAST, `BETA_MID, `BETA_SLOW50, `BETA_SLOW60, `BETA_SLOWEST};
  always #10 clk = ~clk;
  adc_cal_ctrl u_dut (.clk, .rst, .reg_wr, .reg_sel, .reg_wdata, .reg_rdata, .cmd_valid, .cmd,
    .rate_grp, .standby, .raw_valid, .raw_data, .result_data, .result_ready_n, .cal_busy,
    .cal_inputs_mid, .cal_inputs_ref, .gpio0_clock_output_pin, .gpio0_oe_n);
  sample_source u_src (.clk, .rst, .en, .value(src_val), .raw_valid, .raw_data);
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic signed [95:0] ofs_of();
    logic signed [95:0] a, r;
    a = $signed(m_ofc);
    r = rc[rate_grp];
    return (a * r) >>> 16;
  endfunction : ofs_of
  function automatic logic [23:0] conv(input logic [23:0] x);
    logic signed [95:0] p, f, b;
    p = $signed(x);
    f = m_fsc;
    b = bt[rate_grp];
    p = ((p - ofs_of()) * f * b) >>> 37;
    if (p > 96'sh7f_ffff) return 24'h7f_ffff;
    if (p < -96'sh80_0000) return 24'h80_0000;
    return p[23:0];
  endfunction : conv
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_verdict();
    $display("errors=%0d checks=%0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  task automatic wr(input reg_sel_t s, input logic [23:0] d);
    @(posedge clk) {reg_wr, reg_sel, reg_wdata} <= {1'b1, s, d};
    @(posedge clk) reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input reg_sel_t s, input logic [23:0] exp);
    @(posedge clk) reg_sel <= s;
    repeat (2) @(posedge clk);
    #1 chk(reg_rdata, exp);
  endtask : rd
  task automatic wait_idle();
    int n = 0;
    do @(posedge clk) n++; while (cal_busy !== 1'b0 && n < 5000);
    if (n >= 5000) num_errors++;
    en <= 1'b0;
  endtask : wait_idle
  task automatic upd(input cal_cmd_t c, input logic [23:0] r);
    logic signed [95:0] t, a, q;
    a = al[rate_grp];
    t = $signed(r);
    if (c == CMD_SELF_OFS || c == CMD_SYS_OFS || c == CMD_SELF_FULL)
    begin
      t = (t * a) >>> 23;
      m_ofc = t[23:0];
    end
    if (c == CMD_SELF_GAIN || c == CMD_SYS_GAIN)
    begin
      a = bt[rate_grp];
      t = ((t - ofs_of()) * a) >>> 14;
      if (t <= 0) m_fsc = `FSC_MAX;
      else
      begin
        q = 96'sh4000_0000_0000 / t;
        m_fsc = (q > 96'shff_ffff) ? `FSC_MAX : q[23:0];
      end
    end
  endtask : upd
  task automatic samp(input int k);
    repeat (k)
    begin
      @(posedge clk) {en, src_val} <= {1'b1, 24'($random(seed))};
      repeat (63) @(posedge clk);
    end
    @(posedge clk) en <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : samp
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    if (!rst && raw_valid === 1'b1 && cal_busy === 1'b0 && cmd_valid !== 1'b1)
      exp_q.push_back(conv(raw_data));
    if (rdy_q === 1'b1 && result_ready_n === 1'b0)
      chk(result_data, exp_q.size() > 0 ? exp_q.pop_front() : 24'hxx_xxxx);
    rdy_q <= result_ready_n;
  end
  always @(posedge gpio0_clock_output_pin) edges++;
  initial
  begin
    #1_000_000;
    num_errors++;
    give_verdict();
  end
  initial
  begin
    repeat (12) @(posedge clk);
    {rst, en} <= 2'b01;
    @(posedge clk) #1 chk({23'h00_0000, cal_busy}, 24'h00_0001);
    @(posedge clk) {cmd_valid, cmd} <= {1'b1, CMD_SELF_FULL};
    @(posedge clk) cmd_valid <= 1'b0;
    wait_idle();
    upd(CMD_SELF_FULL, 24'h00_0100);
    rd(SEL_OFFSET, m_ofc);
    rd(SEL_CONTROL, 24'h00_0020);
    m_ofc = 24'h80_0000;
    m_fsc = `FSC_MAX;
    wr(SEL_OFFSET, m_ofc);
    wr(SEL_FULLSCALE, m_fsc);
    rd(SEL_OFFSET, m_ofc);
    rd(SEL_FULLSCALE, m_fsc);
    samp(2);
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clk) rate_grp <= rate_group_t'(i);
      raw = (i == 1 || i == 4) ? 24'h60_0000 | 24'($random(seed) & 24'h00_ffff) :
        24'($random(seed) & 24'h00_0fff);
      src_val <= raw;
      @(posedge clk) {cmd_valid, cmd, en} <= {1'b1, cal_cmd_t'(i), 1'b1};
      @(posedge clk) cmd_valid <= 1'b0;
      wait_idle();
      upd(cal_cmd_t'(i), raw);
      if (i == 2) m_fsc = 24'($random(seed));
      if (i == 2) wr(SEL_FULLSCALE, m_fsc);
      rd(SEL_OFFSET, m_ofc);
      rd(SEL_FULLSCALE, m_fsc);
      samp(3);
    end
    for (int s = 1; s < 4; s++)
    begin
      wr(SEL_CONTROL, 24'(s) << 5);
      repeat (8) @(posedge clk);
      #5 edges = 0;
      repeat (20) @(posedge clk);
      standby <= ~standby;
      repeat (20) @(posedge clk);
      #5 chk(24'(edges), 24'(40 >> (s - 1)));
      chk({23'h00_0000, gpio0_oe_n}, 24'h00_0000);
    end
    wr(SEL_CONTROL, 24'h00_0000);
    repeat (8) @(posedge clk);
    chk({23'h00_0000, gpio0_oe_n}, 24'h00_0001);
    chk(24'(exp_q.size()), 24'h00_0000);
    give_verdict();
  end
endmodule : adc_calibration_and_clock_out_test
`default_nettype wire
